// ===== rtl/rss_slot_config.sv
// Sequencer slot registers and strobe matching for switch, regulator and two outputs
`timescale 1ns/1ps
`include "rss_cfg.svh"
// Behaviour
// RL1: The switch-one slot sits in bits 7..4 of the switch/regulator register, read-write, restorable, reset 7h.
// RL2: The linear regulator slot sits in bits 3..0 of that register, read-write, restorable, reset 3h.
// RL3: The general output three slot sits in bits 7..4 of the general register, read-write, restorable, reset 0h.
// RL4: The general output one slot sits in bits 3..0 of the general register, read-write, restorable, reset 3h.
// RL5: A slot of 3h to Ah enables its output at the strobe of the same number.
// RL6: A slot of 0h, 1h or 2h leaves its output untouched by the sequencer.
// RL7: A slot of Bh to Fh leaves its output outside sequencer control.
// RL8: A register write is taken only after an unlock, and each unlock covers one write.
// RL9: Strobes 1 and 2 run only while the freshness seal flag is zero.

module rss_slot_config
	import rss_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Register access from the management interface
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rd_data,
	output logic reg_rd_valid,
	output logic reg_wr_ack,
	output logic reg_wr_reject,
	// Password unlock grant
	input wire logic unlock_pulse,
	// Restore from nonvolatile storage
	input wire logic nv_load,
	input wire logic [7:0] nv_sw_reg,
	input wire logic [7:0] nv_gp_reg,
	// Sequencer strobes
	input wire logic [10:1] strobe_active,
	input wire logic seq_clear,
	input wire logic freshness_seal_flag,
	output logic [`RSS_BACKUP_STROBES-1:0] backup_strobe_go,
	// Per output: 0 regulator, 1 switch, 2 output one, 3 output three
	output logic [3:0] seq_enable,
	output logic [3:0] seq_controlled
);

	rss_state_t st;
	rss_state_t next_st;
	logic [3:0] slot [4];
	logic [3:0] hit;
	logic addr_hit;

	////////////////////////////////////////////////////////////////////////////
	// Slot fields per output
	assign slot[0] = st.sw_reg[`RSS_LO_FIELD_LSB +: 4]; // RL2
	assign slot[1] = st.sw_reg[`RSS_HI_FIELD_LSB +: 4]; // RL1
	assign slot[2] = st.gp_reg[`RSS_LO_FIELD_LSB +: 4]; // RL4
	assign slot[3] = st.gp_reg[`RSS_HI_FIELD_LSB +: 4]; // RL3

	// One decoder per output
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_slot
			rss_slot_decode u_dec (
				.slot(slot[gi]),
				.strobe_active(strobe_active),
				.controlled(seq_controlled[gi]),
				.hit(hit[gi])
			);
		end
	endgenerate

	// Backup strobes gated by the freshness seal
	assign backup_strobe_go = freshness_seal_flag ? '0 : strobe_active[2:1]; // RL9

	assign addr_hit = (reg_addr == `RSS_SEQ_SW_REG_ADDR) || (reg_addr == `RSS_SEQ_GP_REG_ADDR);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_st = st;
		next_st.rd_valid = 1'b0;
		next_st.wr_ack = 1'b0;
		next_st.wr_reject = 1'b0;
		// Register read, unmapped reads as zero
		if (reg_rd_en)
		begin
			next_st.rd_valid = 1'b1;
			if (reg_addr == `RSS_SEQ_SW_REG_ADDR)
				next_st.rd_data = st.sw_reg;
			else if (reg_addr == `RSS_SEQ_GP_REG_ADDR)
				next_st.rd_data = st.gp_reg;
			else
				next_st.rd_data = 8'h00;
		end
		// Protected write consumes the unlock
		if (reg_wr_en)
		begin
			if (addr_hit && st.armed)
			begin
				next_st.wr_ack = 1'b1; // RL8
				if (reg_addr == `RSS_SEQ_SW_REG_ADDR)
					next_st.sw_reg = reg_wr_data; // RL1 RL2
				else
					next_st.gp_reg = reg_wr_data; // RL3 RL4
			end
			else
				next_st.wr_reject = 1'b1; // RL8
			if (addr_hit)
				next_st.armed = 1'b0; // RL8
		end
		// New unlock wins over the consuming write
		if (unlock_pulse)
			next_st.armed = 1'b1; // RL8
		// Restore overrides a write in the same cycle
		if (nv_load)
		begin
			next_st.sw_reg = nv_sw_reg; // RL1 RL2
			next_st.gp_reg = nv_gp_reg; // RL3 RL4
		end
		// Strobe match sets, clear loses to a match
		next_st.enable = (st.enable & ~{4{seq_clear}}) | hit; // RL5 RL6 RL7
		if (srst)
		begin
			next_st = '0;
			next_st.sw_reg = `RSS_SEQ_SW_REG_RESET; // RL1 RL2
			next_st.gp_reg = `RSS_SEQ_GP_REG_RESET; // RL3 RL4
		end
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs from flip-flops
	assign reg_rd_data = st.rd_data;
	assign reg_rd_valid = st.rd_valid;
	assign reg_wr_ack = st.wr_ack;
	assign reg_wr_reject = st.wr_reject;
	assign seq_enable = st.enable;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// Reset values of the fields
	switch_reset_val_a: assert property ( // RL1
		$past(srst) && !nv_load |-> slot[1] == `RSS_SWITCH_ONE_RESET)
		else $error("switch slot reset value wrong");
	regulator_reset_val_a: assert property ( // RL2
		$past(srst) |-> slot[0] == `RSS_LIN_REG_RESET)
		else $error("regulator slot reset value wrong");
	gp_three_reset_a: assert property ( // RL3
		$past(srst) |-> slot[3] == `RSS_GP_THREE_RESET)
		else $error("output three slot reset value wrong");
	gp_one_reset_a: assert property ( // RL4
		$past(srst) |-> slot[2] == `RSS_GP_ONE_RESET)
		else $error("output one slot reset value wrong");
	// Matching strobe enables the output next cycle and it holds without clear
	strobe_enable_a: assert property ( // RL5
		seq_controlled[1] && strobe_active[slot[1]]
		|=> seq_enable[1] ##1 ($past(seq_clear) || seq_enable[1]))
		else $error("switch not enabled at its strobe");
	low_code_idle_a: assert property ( // RL6
		slot[2] <= 4'h2 && !seq_enable[2] |=> !seq_enable[2])
		else $error("low slot code enabled output one");
	high_code_free_a: assert property ( // RL7
		slot[3] >= 4'hB |-> !seq_controlled[3])
		else $error("high slot code treated as sequenced");
	locked_write_a: assert property ( // RL8
		reg_wr_en && !st.armed && !nv_load |=> reg_wr_reject && $stable(st.sw_reg) && $stable(st.gp_reg))
		else $error("write taken without unlock");
	unlock_once_a: assert property ( // RL8
		reg_wr_en && addr_hit && st.armed && !unlock_pulse |=> !st.armed ##0 reg_wr_ack)
		else $error("unlock not consumed by write");
	seal_gate_a: assert property ( // RL9
		freshness_seal_flag |-> backup_strobe_go == '0)
		else $error("backup strobe ran with seal broken");
	read_back_a: assert property (
		reg_rd_en && reg_addr == `RSS_SEQ_GP_REG_ADDR |=> reg_rd_valid && reg_rd_data == $past(st.gp_reg))
		else $error("read data wrong");

	// Writes and restores land in the registers
	sw_write_a: assert property ( // RL1 RL2
		reg_wr_en && st.armed && reg_addr == `RSS_SEQ_SW_REG_ADDR && !nv_load
		|=> st.sw_reg == $past(reg_wr_data))
		else $error("switch register write lost");
	gp_write_a: assert property ( // RL3 RL4
		reg_wr_en && st.armed && reg_addr == `RSS_SEQ_GP_REG_ADDR && !nv_load
		|=> st.gp_reg == $past(reg_wr_data))
		else $error("general register write lost");
	nv_restore_a: assert property ( // RL1 RL2 RL3 RL4
		nv_load |=> st.sw_reg == $past(nv_sw_reg) && st.gp_reg == $past(nv_gp_reg))
		else $error("restore from storage lost");
	armed_reset_a: assert property ( // RL8
		$past(srst) |-> !st.armed)
		else $error("unlock survived reset");

	// Reads of the switch register and of unmapped addresses
	sw_read_a: assert property ( // RL1 RL2
		reg_rd_en && reg_addr == `RSS_SEQ_SW_REG_ADDR |=> reg_rd_data == $past(st.sw_reg))
		else $error("switch register read wrong");
	unmapped_read_a: assert property (
		reg_rd_en && !addr_hit |=> reg_rd_valid && reg_rd_data == 8'h00)
		else $error("unmapped read not zero");

	// Strobe matches on the regulator and output one, and clear without a match
	reg_strobe_a: assert property ( // RL5
		seq_controlled[0] && strobe_active[slot[0]] |=> seq_enable[0])
		else $error("regulator not enabled at its strobe");
	gp_one_strobe_a: assert property ( // RL5
		seq_controlled[2] && strobe_active[slot[2]] |=> seq_enable[2])
		else $error("output one not enabled at its strobe");
	clear_drop_a: assert property ( // RL5
		seq_clear && !hit[1] |=> !seq_enable[1])
		else $error("switch enable survived a clear");

	// Main scenarios
	wr_taken_c: cover property (reg_wr_en && st.armed && addr_hit);
	wr_refused_c: cover property (reg_wr_en && !st.armed && addr_hit);
	enable_hit_c: cover property (hit[3] && !seq_enable[3]);
	backup_go_c: cover property (backup_strobe_go != '0);
	restore_c: cover property (nv_load);

endmodule

// ===== rtl/rss_cfg.svh
// Register offsets, field positions, reset values and slot codes for the slot config block
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// Register subaddresses
`define RSS_SEQ_SW_REG_ADDR 8'h25
`define RSS_SEQ_GP_REG_ADDR 8'h26

// Reset values of both registers
`define RSS_SEQ_SW_REG_RESET 8'h73
`define RSS_SEQ_GP_REG_RESET 8'h03

// Field positions, low nibble and high nibble
`define RSS_LO_FIELD_LSB 0
`define RSS_HI_FIELD_LSB 4

// Field reset values
`define RSS_SWITCH_ONE_RESET 4'h7
`define RSS_LIN_REG_RESET 4'h3
`define RSS_GP_THREE_RESET 4'h0
`define RSS_GP_ONE_RESET 4'h3

// Slot codes that select a strobe
`define RSS_SLOT_FIRST 4'h3
`define RSS_SLOT_LAST 4'hA

// Strobes that serve the backup domain only
`define RSS_BACKUP_STROBES 2

`endif

// ===== rtl/rss_pkg.sv
// Types shared by the slot config block
package rss_pkg;

	// Whole state of the slot config block
	typedef struct packed {
		logic [7:0] sw_reg;
		logic [7:0] gp_reg;
		logic armed;
		logic [3:0] enable;
		logic [7:0] rd_data;
		logic rd_valid;
		logic wr_ack;
		logic wr_reject;
	} rss_state_t;

endpackage

// ===== rtl/rss_slot_decode.sv
// Decoder of one slot field against the strobe lines
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_slot_decode
	import rss_pkg::*;
(
	// Slot field
	input wire logic [3:0] slot,
	// Strobe lines, bit n is strobe n
	input wire logic [10:1] strobe_active,
	// Decode results
	output logic controlled,
	output logic hit
);

	logic [15:0] strobe_map;

	// Codes 3 to A pick a strobe, all others leave the output alone
	always_comb
	begin
		strobe_map = {5'h00, strobe_active, 1'b0};
		controlled = (slot >= `RSS_SLOT_FIRST) && (slot <= `RSS_SLOT_LAST); // RL5 RL6 RL7
		hit = controlled && strobe_map[slot]; // RL5
	end

endmodule

// ===== tb/testbench.sv
// Testbench for the sequencer slot register block
`timescale 1ns/1ps
`include "rss_cfg.svh"

module testbench;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wr_data = 8'h00;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic unlock_pulse = 1'b0;
	logic nv_load = 1'b0;
	logic [7:0] nv_sw_reg = 8'h73;
	logic [7:0] nv_gp_reg = 8'h5A;
	logic [10:1] strobe_active = 10'h000;
	logic seq_clear = 1'b0;
	logic freshness_seal_flag = 1'b0;
	logic [7:0] reg_rd_data;
	logic reg_rd_valid;
	logic reg_wr_ack;
	logic reg_wr_reject;
	logic [1:0] backup_strobe_go;
	logic [3:0] seq_enable;
	logic [3:0] seq_controlled;
	logic [10:1] s;
	logic h;
	int n_errors = 0;
	int checked = 0;

	rss_slot_config rss_slot_config_i (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .reg_wr_ack(reg_wr_ack),
		.reg_wr_reject(reg_wr_reject), .unlock_pulse(unlock_pulse), .nv_load(nv_load),
		.nv_sw_reg(nv_sw_reg), .nv_gp_reg(nv_gp_reg), .strobe_active(strobe_active),
		.seq_clear(seq_clear), .freshness_seal_flag(freshness_seal_flag),
		.backup_strobe_go(backup_strobe_go), .seq_enable(seq_enable),
		.seq_controlled(seq_controlled));

	// Clock, 100 MHz
	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One-write password grant
	task automatic unl;
		@(negedge sys_clk);
		unlock_pulse = 1'b1;
		@(negedge sys_clk);
		unlock_pulse = 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge sys_clk);
		reg_wr_en = 1'b0;
		chk({6'h00, reg_wr_ack, reg_wr_reject}, {6'h00, ok, !ok});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge sys_clk);
		reg_rd_en = 1'b0;
		chk({7'h00, reg_rd_valid}, 8'h01);
		chk(reg_rd_data, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (6) @(negedge sys_clk);
		srst = 1'b0;
		rd(`RSS_SEQ_SW_REG_ADDR, 8'h73);
		rd(`RSS_SEQ_GP_REG_ADDR, 8'h03);
		rd(8'h27, 8'h00);
		chk({4'h0, seq_controlled}, 8'h07);
		wr(`RSS_SEQ_SW_REG_ADDR, 8'h00, 1'b0);
		rd(`RSS_SEQ_SW_REG_ADDR, 8'h73);
		unl;
		wr(`RSS_SEQ_SW_REG_ADDR, 8'hB6, 1'b1);
		wr(`RSS_SEQ_SW_REG_ADDR, 8'h11, 1'b0);
		rd(`RSS_SEQ_SW_REG_ADDR, 8'hB6);
		unl;
		wr(8'h27, 8'h44, 1'b0);
		@(negedge sys_clk);
		nv_load = 1'b1;
		@(negedge sys_clk);
		nv_load = 1'b0;
		rd(`RSS_SEQ_SW_REG_ADDR, 8'h73);
		rd(`RSS_SEQ_GP_REG_ADDR, 8'h5A);
		// Every slot code on both general outputs, strobe of the same number for codes 1 to A, strobe 3 for the others
		for (int v = 0; v < 16; v++)
		begin
			h = (v >= 3 && v <= 10);
			s = (v >= 1 && v <= 10) ? (10'h001 << (v - 1)) : 10'h004;
			unl;
			wr(`RSS_SEQ_GP_REG_ADDR, {v[3:0], v[3:0]}, 1'b1);
			chk({4'h0, seq_controlled}, {4'h0, h, h, 2'b11});
			seq_clear = 1'b1;
			@(negedge sys_clk);
			seq_clear = 1'b0;
			strobe_active = s;
			@(negedge sys_clk);
			strobe_active = 10'h000;
			chk({4'h0, seq_enable}, {4'h0, h, h, s[7], s[3]});
		end
		// Backup strobes pass only while the seal is intact
		for (int f = 0; f < 2; f++)
		begin
			@(negedge sys_clk);
			freshness_seal_flag = f[0];
			strobe_active = 10'h003;
			#1;
			chk({6'h00, backup_strobe_go}, f ? 8'h00 : 8'h03);
		end
		strobe_active = 10'h000;
		// Mid-run reset restores defaults, drops enables and the unlock
		unl;
		@(negedge sys_clk);
		srst = 1'b1;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		chk({4'h0, seq_enable}, 8'h00);
		rd(`RSS_SEQ_SW_REG_ADDR, 8'h73);
		rd(`RSS_SEQ_GP_REG_ADDR, 8'h03);
		wr(`RSS_SEQ_GP_REG_ADDR, 8'h55, 1'b0);
		rd(`RSS_SEQ_GP_REG_ADDR, 8'h03);
		stop_test;
	end
endmodule
